// ---- rtl/asce_pkg.sv ----
// Constants, register map and control layout of the audio serial
// bit-clock and edge selection block.
// Assumes a 32-bit APB master and a 100 MHz mclk.
package asce_pkg;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_DIV = 8'h04;
	localparam logic [7:0] ADDR_TXDATA = 8'h08;
	localparam logic [7:0] ADDR_RXDATA = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int CTRL_WIDTH = 8;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int DIV_WIDTH = 16;
	localparam logic [15:0] DIV_RESET = 16'h0004;
	localparam int STAT_TX_PENDING = 0;
	localparam int STAT_TX_BUSY = 1;
	localparam int STAT_RX_VALID = 2;
	localparam int WORD_BITS = 32;

	// Control register, bit 7 downward
	typedef struct packed {
		logic rxEnable;        // bit 7
		logic txFsDrive;       // bit 6
		logic rxClockPolarity; // bit 5
		logic txClockPolarity; // bit 4
		logic rxPinDir;        // bit 3
		logic rxClockSourceSel;// bit 2
		logic txPinDir;        // bit 1
		logic txClockSourceSel;// bit 0
	} asce_ctrl_t;

	// Transmit-side pin bundle
	typedef struct packed {
		logic fsOut;
		logic fsOe;
		logic dataOut;
		logic dataOe;
	} asce_txpins_t;

endpackage : asce_pkg

// ---- rtl/asce_port.sv ----
// Bit-clock source selection, edge polarity and pin timing for the
// transmit and receive sections of a multichannel audio serial port.
// Assumes an APB master on mclk; the receive bit-clock pin level
// (whoever drives it) is looped back on rxLinkClk by the pad ring.
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps

// What this block does
// - Tx mode 1, dir 1: internal clock driven out
// - Tx mode 0, dir 0: clock from pin
// - Tx mode 0, dir 1: external source, pin output
// - Rx mode 1, dir 1: internal clock driven out
// - Rx mode 0, dir 0: clock from pin
// - Rx mode 0, dir 1: external source, pin output
// - Polarity 0: tx rising, rx falling edge
// - Polarity 1: tx falling, rx rising edge
// - Frame sync sampled with receive data edge
// - Driven frame sync changes on transmit edge
// - Data output changes on transmit edge
// - Data pin released after last bit unless another word is pending
module asce_port import asce_pkg::*; #(
	parameter int WORD = WORD_BITS
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxLinkClk,
	input wire logic txBitClockPinIn,
	output logic txBitClockPinOut,
	output logic txBitClockPinOe,
	output logic rxBitClockPinOut,
	output logic rxBitClockPinOe,
	output logic txFrameSyncPinOut,
	output logic txFrameSyncPinOe,
	output logic serializerDataPinOut,
	output logic serializerDataPinOe,
	input wire logic rxFrameSyncPinIn,
	input wire logic rxSerializerDataPinIn
);

	// ----------------------------------------
	// Register state on mclk
	// ----------------------------------------
	asce_ctrl_t ctrl_q;
	logic [DIV_WIDTH-1:0] div_q;
	logic [WORD-1:0] txData_q;
	logic txPending_q;
	logic [WORD-1:0] rxData_q;
	logic rxValid_q;
	logic [31:0] prdata_q;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	// Phase and address decode; every hit is one aligned word
	wire logic accessPhase = psel & penable;
	wire logic hitCtrl = paddr == ADDR_CTRL;
	wire logic hitDiv = paddr == ADDR_DIV;
	wire logic hitTx = paddr == ADDR_TXDATA;
	wire logic hitRx = paddr == ADDR_RXDATA;
	wire logic hitStat = paddr == ADDR_STATUS;
	wire logic hitAny = hitCtrl | hitDiv | hitTx | hitRx | hitStat;
	wire logic wrCtrl = accessPhase & pwrite & hitCtrl;
	wire logic wrDiv = accessPhase & pwrite & hitDiv;
	wire logic wrTx = accessPhase & pwrite & hitTx;
	wire logic rdRx = accessPhase & ~pwrite & hitRx;
	wire logic setupRead = psel & ~penable & ~pwrite;

	// Zero wait states; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = accessPhase & ~hitAny;
	assign prdata = prdata_q;

	// ----------------------------------------
	// Internal bit-clock generator
	// ----------------------------------------
	logic [DIV_WIDTH-1:0] divCnt_q;
	logic intClk_q;
	wire logic divWrap = divCnt_q >= div_q;
	wire logic [DIV_WIDTH-1:0] divCnt_d = divWrap ? '0 :
		divCnt_q + {{(DIV_WIDTH-1){1'b0}}, 1'b1};

	// Half period is div_q+1 mclk cycles; zero gives mclk/2
	// A divider write mid-count only stretches or cuts one half period
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			divCnt_q <= '0;
			intClk_q <= 1'b0;
		end else begin
			divCnt_q <= divCnt_d;
			intClk_q <= divWrap ? ~intClk_q : intClk_q;
		end
	end

	// ----------------------------------------
	// Bit-clock pin drivers
	// ----------------------------------------
	// Pin direction alone decides the output buffer; in the external
	// output case the pin still carries the generator's clock.
	// The rx pin works alike; rx edges always come back from the pad.
	assign txBitClockPinOut = intClk_q;
	assign txBitClockPinOe = ctrl_q.txPinDir;
	assign rxBitClockPinOut = intClk_q;
	assign rxBitClockPinOe = ctrl_q.rxPinDir;

	// ----------------------------------------
	// External transmit clock synchroniser
	// ----------------------------------------
	logic txPinMeta_q;
	logic txPinSync_q;
	logic txPinLast_q;
	// Edges show three mclk late, so a pin clock needs long phases
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			txPinMeta_q <= 1'b0;
			txPinSync_q <= 1'b0;
			txPinLast_q <= 1'b0;
		end else begin
			txPinMeta_q <= txBitClockPinIn;
			txPinSync_q <= txPinMeta_q;
			txPinLast_q <= txPinSync_q;
		end
	end

	// ----------------------------------------
	// Transmit edge selection
	// ----------------------------------------
	// Only mode 1 with dir 1 uses the generator; mode 0 takes the pin in both
	// direction settings, so a mode 0 output pin just loops back.
	wire logic intRise = divWrap & ~intClk_q;
	wire logic intFall = divWrap & intClk_q;
	wire logic extRise = txPinSync_q & ~txPinLast_q;
	wire logic extFall = ~txPinSync_q & txPinLast_q;
	wire logic txInternal = ctrl_q.txClockSourceSel & ctrl_q.txPinDir;
	wire logic txRise = txInternal ? intRise : extRise;
	wire logic txFall = txInternal ? intFall : extFall;
	wire logic txEdge = ctrl_q.txClockPolarity ? txFall : txRise;

	// ----------------------------------------
	// Transmit serializer
	// ----------------------------------------
	logic [WORD-1:0] txShift_q;
	logic [$clog2(WORD+1)-1:0] txLeft_q;
	asce_txpins_t txPins_q;
	wire logic txBusy = txLeft_q != '0;
	wire logic txStart = txEdge & ~txBusy & txPending_q;
	wire logic txMore = txEdge & txBusy;
	wire logic txRelease = txEdge & ~txBusy & ~txPending_q;
	wire logic [$clog2(WORD+1)-1:0] txWordLen =
		($clog2(WORD+1))'(WORD);

	// Every pin change waits for a transmit edge; the word after the
	// last bit follows back to back when already pending.
	// An idle transmit edge re-applies the frame-sync enable setting.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			txShift_q <= '0;
			txLeft_q <= '0;
			txPins_q <= '0;
		end else if (txStart) begin
			txShift_q <= txData_q << 1;
			txLeft_q <= txWordLen - 1'b1;
			txPins_q.dataOut <= txData_q[WORD-1];
			txPins_q.dataOe <= 1'b1;
			txPins_q.fsOut <= 1'b1;
			txPins_q.fsOe <= ctrl_q.txFsDrive;
		end else if (txMore) begin
			txShift_q <= txShift_q << 1;
			txLeft_q <= txLeft_q - 1'b1;
			txPins_q.dataOut <= txShift_q[WORD-1];
			txPins_q.fsOut <= 1'b0;
			txPins_q.fsOe <= ctrl_q.txFsDrive;
		end else if (txRelease) begin
			txPins_q.dataOe <= 1'b0;
			txPins_q.dataOut <= 1'b0;
			txPins_q.fsOut <= 1'b0;
			txPins_q.fsOe <= ctrl_q.txFsDrive;
		end
	end

	// Pins come straight from the registered bundle, free of glitches
	assign serializerDataPinOut = txPins_q.dataOut;
	assign serializerDataPinOe = txPins_q.dataOe;
	assign txFrameSyncPinOut = txPins_q.fsOut;
	assign txFrameSyncPinOe = txPins_q.fsOe;

	// ----------------------------------------
	// Receive link domain
	// ----------------------------------------
	// Polarity 0 samples on falling pin edges, so the clock is
	// inverted; change rx polarity only while rx is disabled.
	wire logic rxSampleClk = rxLinkClk ^ ~ctrl_q.rxClockPolarity;
	logic rxRstMeta_q;
	logic rxRstSync_q;
	logic rxEnMeta_q;
	logic rxEnSync_q;
	logic [WORD-1:0] rxShift_q;
	logic [$clog2(WORD+1)-1:0] rxLeft_q;
	logic [WORD-1:0] rxWord_q;
	logic rxDoneTgl_q;

	// Reset release brought into the link domain
	// rxRstSync_q stays low until the link clock has run two edges
	always_ff @(posedge rxSampleClk or negedge rst_n) begin
		if (!rst_n) begin
			rxRstMeta_q <= 1'b0;
			rxRstSync_q <= 1'b0;
		end else begin
			rxRstMeta_q <= 1'b1;
			rxRstSync_q <= rxRstMeta_q;
		end
	end

	// Enable passes two flops; it only gates the start of a word
	always_ff @(posedge rxSampleClk or negedge rst_n) begin
		if (!rst_n) begin
			rxEnMeta_q <= 1'b0;
			rxEnSync_q <= 1'b0;
		end else begin
			rxEnMeta_q <= ctrl_q.rxEnable;
			rxEnSync_q <= rxEnMeta_q;
		end
	end

	// Frame sync and data are latched on the same sampling edge
	// A frame sync in the middle of a word is ignored
	wire logic rxGo = rxEnSync_q & rxFrameSyncPinIn;
	wire logic rxLast = rxLeft_q == {{($clog2(WORD+1)-1){1'b0}}, 1'b1};
	always_ff @(posedge rxSampleClk or negedge rxRstSync_q) begin
		if (!rxRstSync_q) begin
			rxShift_q <= '0;
			rxLeft_q <= '0;
			rxWord_q <= '0;
			rxDoneTgl_q <= 1'b0;
		end else if (rxLeft_q == '0) begin
			if (rxGo) begin
				rxShift_q <= {rxShift_q[WORD-2:0], rxSerializerDataPinIn};
				rxLeft_q <= txWordLen - 1'b1;
			end
		end else begin
			rxShift_q <= {rxShift_q[WORD-2:0], rxSerializerDataPinIn};
			rxLeft_q <= rxLeft_q - 1'b1;
			if (rxLast) begin
				rxWord_q <= {rxShift_q[WORD-2:0], rxSerializerDataPinIn};
				rxDoneTgl_q <= ~rxDoneTgl_q;
			end
		end
	end

	// ----------------------------------------
	// Word-done crossing into mclk
	// ----------------------------------------
	// rxWord_q holds for a whole word time after the toggle, far
	// longer than the three mclk cycles the crossing needs.
	logic rxTglMeta_q;
	logic rxTglSync_q;
	logic rxTglLast_q;
	// Two flops for the toggle, a third to find its change
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rxTglMeta_q <= 1'b0;
			rxTglSync_q <= 1'b0;
			rxTglLast_q <= 1'b0;
		end else begin
			rxTglMeta_q <= rxDoneTgl_q;
			rxTglSync_q <= rxTglMeta_q;
			rxTglLast_q <= rxTglSync_q;
		end
	end
	wire logic rxWordIn = rxTglSync_q ^ rxTglLast_q;

	// ----------------------------------------
	// Software-visible registers
	// ----------------------------------------
	// Control and divider change on writes only
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= asce_ctrl_t'(CTRL_RESET);
			div_q <= DIV_RESET;
		end else begin
			ctrl_q <= wrCtrl ? asce_ctrl_t'(pwdata[CTRL_WIDTH-1:0]) : ctrl_q;
			div_q <= wrDiv ? pwdata[DIV_WIDTH-1:0] : div_q;
		end
	end

	// A new write wins over a start clear in one cycle;
	// a write while pending replaces that word
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			txData_q <= '0;
			txPending_q <= 1'b0;
		end else begin
			txData_q <= wrTx ? pwdata[WORD-1:0] : txData_q;
			txPending_q <= wrTx | (txPending_q & ~txStart);
		end
	end

	// A new word wins over a read clear in one cycle;
	// rxData_q only moves when the toggle arrives
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rxData_q <= '0;
			rxValid_q <= 1'b0;
		end else begin
			rxData_q <= rxWordIn ? rxWord_q : rxData_q;
			rxValid_q <= rxWordIn | (rxValid_q & ~rdRx);
		end
	end

	// ----------------------------------------
	// Read data, captured in the setup cycle
	// ----------------------------------------
	// Status bits placed at their package positions
	// Unused status bits read as zero
	logic [31:0] statusWord;
	always_comb begin
		statusWord = 32'h0000_0000;
		statusWord[STAT_TX_PENDING] = txPending_q;
		statusWord[STAT_TX_BUSY] = txBusy;
		statusWord[STAT_RX_VALID] = rxValid_q;
	end
	wire logic [31:0] readMux =
		hitCtrl ? {24'h00_0000, ctrl_q} :
		hitDiv ? {16'h0000, div_q} :
		hitTx ? 32'(txData_q) :
		hitRx ? 32'(rxData_q) :
		hitStat ? statusWord : 32'h0000_0000;
	// Read data settles a cycle early, so the access edge sees it held
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_q <= '0;
		end else begin
			prdata_q <= setupRead ? readMux : prdata_q;
		end
	end

endmodule : asce_port

// ---- testbench/asce_codec.sv ----
// Behavioural codec at the far side of the audio serial pins.
// Assumes the bench resolves the shared clock pins around it.
`timescale 1ns/1ps
module asce_codec (
	output logic bclk,
	output logic fs,
	output logic sd
);
	// ----------------
	// Frame generator
	// ----------------
	// Clock stands still between frames
	initial begin
		bclk = 1'h0;
		fs = 1'h0;
		sd = 1'h0;
	end
	// Four lead-in clocks let the link domain leave reset first
	task automatic send(input logic [31:0] w, input logic p,
		input int half);
		bclk = p;
		#(half);
		for (int i = -4; i < 32; i++) begin
			bclk = !p; // Launch edge, opposite the sampling one
			fs = (i == 0);
			sd = (i < 0) ? !sd : w[31 - i];
			#(half);
			bclk = p;
			#(half);
		end
		fs = 1'h0;
		sd = !sd; // Released line shows no stale bit
	endtask : send
endmodule : asce_codec

// ---- testbench/asce_port_bench.sv ----
// Bench for asce_port: APB master, codec partner, pin capture.
// Assumes asce_pkg, the checker and the codec are compiled first.
`timescale 1ns/1ps
module asce_port_bench import asce_pkg::*;;
	// ----------------
	// Harness
	// ----------------
	logic mclk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, rdat;
	int fails = 0, checked = 0, cyc = 0;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, txOut, txOe, rxOut, rxOe, fsOut, fsOe;
	wire logic sdOut, sdOe, cClk, cFs, cSd;
	wire logic txPin = txOe ? txOut : cClk;
	wire logic rxPin = rxOe ? rxOut : cClk;
	asce_port i_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxLinkClk(rxPin), .txBitClockPinIn(txPin),
		.txBitClockPinOut(txOut), .txBitClockPinOe(txOe),
		.rxBitClockPinOut(rxOut), .rxBitClockPinOe(rxOe),
		.txFrameSyncPinOut(fsOut), .txFrameSyncPinOe(fsOe),
		.serializerDataPinOut(sdOut), .serializerDataPinOe(sdOe),
		.rxFrameSyncPinIn(cFs), .rxSerializerDataPinIn(cSd));
	asce_codec i_codec (.bclk(cClk), .fs(cFs), .sd(cSd));
	// Clock, reset and hang guard
	always #5 mclk = ~mclk;
	initial begin
		repeat (5) @(posedge mclk);
		rst_n <= 1'h1;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			stop_test;
		end
	end
	task automatic chk(input logic [31:0] seen, exp, input string m);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask : chk
	// Request held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		do @(posedge mclk); while (pready !== 1'h1);
		rdat = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic t_regs;
		apb(1'h0, ADDR_DIV, 32'h0000_0000);
		chk(rdat, 32'(DIV_RESET), "div reset");
		apb(1'h1, 8'h14, 32'hFFFF_FFFF);
		chk(32'(err), 32'h0000_0001, "unmapped error");
		apb(1'h1, ADDR_CTRL, 32'hFFFF_FF5A);
		apb(1'h0, ADDR_CTRL, 32'h0000_0000);
		chk(rdat, 32'h0000_005A, "ctrl low byte");
		chk(32'(rxOe), 32'h0000_0001, "rx pin dir");
	endtask : t_regs
	// One word out; capture on the sampling edge of the resolved pin
	task automatic t_tx(input logic [7:0] c, input int half);
		logic [31:0] got;
		apb(1'h1, ADDR_CTRL, {24'h00_0000, c});
		apb(1'h1, ADDR_TXDATA, 32'hA5C3_0F96);
		fork
			if (half > 0) i_codec.send(32'h0000_0000, c[4], half);
			begin
				wait (sdOe === 1'h1);
				for (int i = 0; i < 33; i++) begin
					if (c[4]) @(posedge txPin);
					else @(negedge txPin);
					if (i == 0) chk(32'(fsOut), 32'h0000_0001, "fs");
					if (i == 0) chk(32'(fsOe), 32'(c[6]), "fs oe");
					if (i < 32) got[31 - i] = sdOut;
				end
				chk(32'(sdOe), 32'h0000_0000, "released");
			end
		join
		chk(got, 32'hA5C3_0F96, "tx word");
	endtask : t_tx
	task automatic t_rx(input logic p);
		int n;
		apb(1'h1, ADDR_CTRL, {26'h000_0000, p, 5'h00});
		apb(1'h1, ADDR_CTRL, {24'h00_0000, 1'h1, 1'h0, p, 5'h00});
		i_codec.send(32'h3C96_A55A ^ {32{p}}, p, 6);
		n = 0;
		do begin
			apb(1'h0, ADDR_STATUS, 32'h0000_0000);
			n++;
		end while (rdat[STAT_RX_VALID] !== 1'h1 && n < 20);
		apb(1'h0, ADDR_RXDATA, 32'h0000_0000);
		chk(rdat, 32'h3C96_A55A ^ {32{p}}, "rx word");
		apb(1'h0, ADDR_STATUS, 32'h0000_0000);
		chk(32'(rdat[STAT_RX_VALID]), 32'h0000_0000, "rx valid clear");
	endtask : t_rx
	task automatic stop_test;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : stop_test
	// Slow external clock: the pin is sampled through a synchroniser
	initial begin
		@(posedge rst_n);
		t_regs;
		t_tx(8'h03, 0);
		t_tx(8'h53, 0);
		t_tx(8'h42, 0);
		t_tx(8'h40, 80);
		t_rx(1'h0);
		t_rx(1'h1);
		stop_test;
	end
endmodule : asce_port_bench

// ---- testbench/asce_port_sva.sv ----
// Checker on the asce_port pins and APB answers.
// Assumes a bind to asce_port; edges timed in internal mode only.
`timescale 1ns/1ps
module asce_port_sva (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic txBitClockPinOut,
	input wire logic txBitClockPinOe,
	input wire logic rxBitClockPinOut,
	input wire logic rxBitClockPinOe,
	input wire logic txFrameSyncPinOut,
	input wire logic serializerDataPinOut,
	input wire logic serializerDataPinOe
);
	// ----------------
	// Shadow state
	// ----------------
	logic [7:0] ctrl_q;
	logic clkLast_q;
	wire acc = psel && penable;
	wire mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
	wire lvl = !ctrl_q[4];
	wire intClk = ctrl_q[0] && ctrl_q[1];
	// Transmit edge: generator pin reached its launch level this cycle
	wire txEdge = txBitClockPinOut == lvl && clkLast_q != lvl;
	// Control copy taken at the access edge, as the design does
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= 8'h00;
			clkLast_q <= 1'h0;
		end else begin
			clkLast_q <= txBitClockPinOut;
			if (acc && pwrite && paddr == 8'h00) begin
				ctrl_q <= pwdata[7:0];
			end
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	pready_hi_a: assert property (pready) else $error("pready low");
	bad_addr_a: assert property (acc && !mapped |-> pslverr)
		else $error("no error on unmapped address");
	good_addr_a: assert property (acc && mapped |-> !pslverr)
		else $error("error on mapped address");
	tx_dir_a: assert property (txBitClockPinOe == ctrl_q[1])
		else $error("tx clock pin direction wrong");
	rx_dir_a: assert property (rxBitClockPinOe == ctrl_q[3])
		else $error("rx clock pin direction wrong");
	gen_pair_a: assert property (rxBitClockPinOut == txBitClockPinOut)
		else $error("generator clocks differ");
	data_edge_a: assert property (
		intClk && $changed(serializerDataPinOut) |-> txEdge)
		else $error("data moved off edge");
	hiz_edge_a: assert property (
		intClk && $fell(serializerDataPinOe) |-> txEdge)
		else $error("release off edge");
	fs_edge_a: assert property (
		intClk && $changed(txFrameSyncPinOut) |-> txEdge)
		else $error("frame sync off edge");
	cover property ($rose(serializerDataPinOe));
	cover property (acc && !mapped);
	cover property (intClk && ctrl_q[4] && $fell(serializerDataPinOe));
endmodule : asce_port_sva

bind asce_port asce_port_sva i_sva (.mclk(mclk), .rst_n(rst_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.txBitClockPinOut(txBitClockPinOut), .txBitClockPinOe(txBitClockPinOe),
	.rxBitClockPinOut(rxBitClockPinOut), .rxBitClockPinOe(rxBitClockPinOe),
	.txFrameSyncPinOut(txFrameSyncPinOut),
	.serializerDataPinOut(serializerDataPinOut),
	.serializerDataPinOe(serializerDataPinOe));
